//--- pkg/irq_sense_pkg.sv
// Constants, register map and carrier types of the external request sense block.
// Assumes a 32-bit AXI4-Lite register bus and eight active-low request pins.
package irq_sense_pkg;

   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int NUM_PINS      = 8;
   localparam int ADDR_W        = 8;
   localparam int DATA_W        = 32;
   localparam int SENSE_W       = 2;
   localparam int PRIO_W        = 3;
   localparam int PRIO_STRIDE   = 4;
   localparam int PRIO_TOP_LSB  = 12;
   localparam int PINS_PER_PRIO = 4;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_ENABLE = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_SENSE  = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_PRIO_A = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_PRIO_B = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_FLAGS  = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_MASK   = 8'h14;

   // ---------------------------------------------------------------
   // Reset values and field masks
   // ---------------------------------------------------------------
   localparam logic [7:0]  ENABLE_RESET    = 8'h00;
   localparam logic [15:0] SENSE_RESET     = 16'h0000;
   localparam logic [15:0] PRIO_RESET      = 16'h7777;
   localparam logic [15:0] PRIO_WRITE_MASK = 16'h7777;
   localparam logic [7:0]  FLAGS_RESET     = 8'h00;
   localparam logic [7:0]  MASK_RESET      = 8'h00;
   localparam logic        PIN_IDLE        = 1'h1;

   // ---------------------------------------------------------------
   // Bus answers
   // ---------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      SENSE_LOW  = 2'b00,
      SENSE_FALL = 2'b01,
      SENSE_RISE = 2'b10,
      SENSE_BOTH = 2'b11
   } sense_mode_type;

   typedef struct packed {
      logic [NUM_PINS-1:0]        pending;
      logic [NUM_PINS*PRIO_W-1:0] levels;
   } cpu_req_type;

endpackage : irq_sense_pkg

//--- logic/pin_sense.sv
// One request pin: three-stage synchroniser, filtered level and sense decode.
// Assumes the pin is asynchronous to sys_clk_in and idles high.
`timescale 1ns/100ps
module pin_sense (
   input  wire logic       sys_clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       pin_in,
   input  wire logic [1:0] sense_in,
   output logic            event_out
);

   logic sync1;
   logic sync2;
   logic sync3;
   logic level;
   logic level_prev;

   // ---------------------------------------------------------------
   // Synchroniser and filtered level
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         sync1 <= irq_sense_pkg::PIN_IDLE;
         sync2 <= irq_sense_pkg::PIN_IDLE;
         sync3 <= irq_sense_pkg::PIN_IDLE;
      end else begin
         sync1 <= pin_in;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         level      <= irq_sense_pkg::PIN_IDLE;
         level_prev <= irq_sense_pkg::PIN_IDLE;
      end else begin
         if (sync2 == sync3) begin
            level <= sync3;
         end
         level_prev <= level;
      end
   end

   // ---------------------------------------------------------------
   // Sense decode
   // ---------------------------------------------------------------
   always_comb begin
      case (irq_sense_pkg::sense_mode_type'(sense_in))
         irq_sense_pkg::SENSE_LOW:  event_out = !level;
         irq_sense_pkg::SENSE_FALL: event_out = level_prev && !level;
         irq_sense_pkg::SENSE_RISE: event_out = !level_prev && level;
         irq_sense_pkg::SENSE_BOTH: event_out = level_prev != level;
         default:                   event_out = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   AST_LOW_LEVEL: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (sense_in == 2'b00 && !level) |-> event_out)
      else $error("Low level without request.");
   AST_FALL_EDGE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (sense_in == 2'b01) |-> (event_out == ($past(level) && !level)))
      else $error("Falling edge request wrong.");
   AST_RISE_EDGE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (sense_in == 2'b10 && $rose(level)) |-> event_out)
      else $error("Rising edge missed.");
   AST_BOTH_EDGE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (sense_in == 2'b11) |-> (event_out == (level != $past(level))))
      else $error("Both edge request wrong.");
   AST_SYNC_AGREE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (level != $past(level)) |-> ($past(sync2) == $past(sync3) && level == $past(sync3)))
      else $error("Level changed without agreement.");

endmodule : pin_sense

//--- logic/irq_sense_enable_priority.sv
// Top of the external request block: AXI4-Lite registers, pin sensing, flags, interrupt.
// Assumes one clock sys_clk_in at 200 MHz and a synchronous active-low reset.
`timescale 1ns/100ps
module irq_sense_enable_priority (
   input  wire logic                               sys_clk_in,
   input  wire logic                               rst_n_in,
   input  wire logic [irq_sense_pkg::NUM_PINS-1:0] ext_request_pin_n_in,
   input  wire logic                               axi_awvalid_in,
   input  wire logic [irq_sense_pkg::ADDR_W-1:0]   axi_awaddr_in,
   input  wire logic [2:0]                         axi_awprot_in,
   output logic                                    axi_awready_out,
   input  wire logic                               axi_wvalid_in,
   input  wire logic [irq_sense_pkg::DATA_W-1:0]   axi_wdata_in,
   input  wire logic [3:0]                         axi_wstrb_in,
   output logic                                    axi_wready_out,
   output logic                                    axi_bvalid_out,
   output logic [1:0]                              axi_bresp_out,
   input  wire logic                               axi_bready_in,
   input  wire logic                               axi_arvalid_in,
   input  wire logic [irq_sense_pkg::ADDR_W-1:0]   axi_araddr_in,
   input  wire logic [2:0]                         axi_arprot_in,
   output logic                                    axi_arready_out,
   output logic                                    axi_rvalid_out,
   output logic [irq_sense_pkg::DATA_W-1:0]        axi_rdata_out,
   output logic [1:0]                              axi_rresp_out,
   input  wire logic                               axi_rready_in,
   output irq_sense_pkg::cpu_req_type              cpu_req_out,
   output logic                                    irq_out
);

   logic [7:0]                             irq_enable;
   logic [15:0]                            irq_sense_select;
   logic [15:0]                            prio_a;
   logic [15:0]                            prio_b;
   logic [7:0]                             irq_request_flags;
   logic [7:0]                             irq_mask;
   logic [irq_sense_pkg::NUM_PINS-1:0]     pin_event;
   logic                                   aw_full;
   logic [irq_sense_pkg::ADDR_W-1:0]       aw_addr;
   logic                                   w_full;
   logic [irq_sense_pkg::DATA_W-1:0]       w_data;
   logic [3:0]                             w_strb;
   logic                                   do_write;
   logic                                   b_done;
   logic                                   ar_take;
   logic                                   wr_hit;
   logic [irq_sense_pkg::DATA_W-1:0]       rd_word;
   logic                                   rd_hit;
   logic [7:0]                             flag_clear;
   logic [7:0]                             next_flags;
   logic [irq_sense_pkg::NUM_PINS*irq_sense_pkg::PRIO_W-1:0] next_levels;

   function automatic logic [15:0] merge16(input logic [15:0] cur,
                                           input logic [31:0] wd,
                                           input logic [3:0]  st);
      logic [15:0] res;
      res = cur;
      if (st[0]) begin
         res[7:0] = wd[7:0];
      end
      if (st[1]) begin
         res[15:8] = wd[15:8];
      end
      return res;
   endfunction : merge16

   // ---------------------------------------------------------------
   // Pin sensing
   // ---------------------------------------------------------------
   for (genvar p = 0; p < irq_sense_pkg::NUM_PINS; p++) begin : g_pin
      pin_sense u_sense (
         .sys_clk_in (sys_clk_in),
         .rst_n_in   (rst_n_in),
         .pin_in     (ext_request_pin_n_in[p]),
         .sense_in   (irq_sense_select[2*p +: 2]),
         .event_out  (pin_event[p])
      );
   end

   // ---------------------------------------------------------------
   // Write channel
   // ---------------------------------------------------------------
   assign do_write = aw_full && w_full && !axi_bvalid_out;
   assign b_done   = axi_bvalid_out && axi_bready_in;
   assign ar_take  = axi_arready_out && axi_arvalid_in;

   always_comb begin
      case (aw_addr)
         irq_sense_pkg::OFF_ENABLE,
         irq_sense_pkg::OFF_SENSE,
         irq_sense_pkg::OFF_PRIO_A,
         irq_sense_pkg::OFF_PRIO_B,
         irq_sense_pkg::OFF_FLAGS,
         irq_sense_pkg::OFF_MASK: wr_hit = 1'b1;
         default:                 wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         axi_awready_out <= 1'b0;
         aw_full         <= 1'b0;
         aw_addr         <= '0;
      end else begin
         if (axi_awready_out && axi_awvalid_in) begin
            aw_full         <= 1'b1;
            aw_addr         <= axi_awaddr_in;
            axi_awready_out <= 1'b0;
         end else if (!aw_full && !axi_bvalid_out) begin
            axi_awready_out <= 1'b1;
         end
         if (b_done) begin
            aw_full <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         axi_wready_out <= 1'b0;
         w_full         <= 1'b0;
         w_data         <= '0;
         w_strb         <= '0;
      end else begin
         if (axi_wready_out && axi_wvalid_in) begin
            w_full         <= 1'b1;
            w_data         <= axi_wdata_in;
            w_strb         <= axi_wstrb_in;
            axi_wready_out <= 1'b0;
         end else if (!w_full && !axi_bvalid_out) begin
            axi_wready_out <= 1'b1;
         end
         if (b_done) begin
            w_full <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         axi_bvalid_out <= 1'b0;
         axi_bresp_out  <= irq_sense_pkg::RESP_OKAY;
      end else if (do_write) begin
         axi_bvalid_out <= 1'b1;
         axi_bresp_out  <= wr_hit ? irq_sense_pkg::RESP_OKAY : irq_sense_pkg::RESP_SLVERR;
      end else if (b_done) begin
         axi_bvalid_out <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         irq_enable <= irq_sense_pkg::ENABLE_RESET;
      end else if (do_write && aw_addr == irq_sense_pkg::OFF_ENABLE && w_strb[0]) begin
         irq_enable <= w_data[7:0];
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         irq_sense_select <= irq_sense_pkg::SENSE_RESET;
      end else if (do_write && aw_addr == irq_sense_pkg::OFF_SENSE) begin
         irq_sense_select <= merge16(irq_sense_select, w_data, w_strb);
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         prio_a <= irq_sense_pkg::PRIO_RESET;
         prio_b <= irq_sense_pkg::PRIO_RESET;
      end else if (do_write && aw_addr == irq_sense_pkg::OFF_PRIO_A) begin
         prio_a <= merge16(prio_a, w_data, w_strb) & irq_sense_pkg::PRIO_WRITE_MASK;
      end else if (do_write && aw_addr == irq_sense_pkg::OFF_PRIO_B) begin
         prio_b <= merge16(prio_b, w_data, w_strb) & irq_sense_pkg::PRIO_WRITE_MASK;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         irq_mask <= irq_sense_pkg::MASK_RESET;
      end else if (do_write && aw_addr == irq_sense_pkg::OFF_MASK && w_strb[0]) begin
         irq_mask <= w_data[7:0];
      end
   end

   // ---------------------------------------------------------------
   // Request flags
   // ---------------------------------------------------------------
   always_comb begin
      flag_clear = '0;
      if (do_write && aw_addr == irq_sense_pkg::OFF_FLAGS && w_strb[0]) begin
         flag_clear = w_data[7:0];
      end
      next_flags = (irq_request_flags & ~flag_clear) | pin_event;
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         irq_request_flags <= irq_sense_pkg::FLAGS_RESET;
      end else begin
         irq_request_flags <= next_flags;
      end
   end

   // ---------------------------------------------------------------
   // Requests to the CPU
   // ---------------------------------------------------------------
   always_comb begin
      next_levels = '0;
      for (int p = 0; p < irq_sense_pkg::NUM_PINS; p++) begin
         if (p < irq_sense_pkg::PINS_PER_PRIO) begin
            next_levels[p*irq_sense_pkg::PRIO_W +: irq_sense_pkg::PRIO_W] =
               prio_a[irq_sense_pkg::PRIO_TOP_LSB - irq_sense_pkg::PRIO_STRIDE*p
                      +: irq_sense_pkg::PRIO_W];
         end else begin
            next_levels[p*irq_sense_pkg::PRIO_W +: irq_sense_pkg::PRIO_W] =
               prio_b[irq_sense_pkg::PRIO_TOP_LSB
                      - irq_sense_pkg::PRIO_STRIDE*(p - irq_sense_pkg::PINS_PER_PRIO)
                      +: irq_sense_pkg::PRIO_W];
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         cpu_req_out <= '0;
         irq_out     <= 1'b0;
      end else begin
         cpu_req_out.pending <= irq_request_flags & irq_enable;
         cpu_req_out.levels  <= next_levels;
         irq_out             <= |(irq_request_flags & irq_enable & irq_mask);
      end
   end

   // ---------------------------------------------------------------
   // Read channel
   // ---------------------------------------------------------------
   always_comb begin
      rd_hit  = 1'b1;
      rd_word = '0;
      case (axi_araddr_in)
         irq_sense_pkg::OFF_ENABLE: rd_word[7:0]  = irq_enable;
         irq_sense_pkg::OFF_SENSE:  rd_word[15:0] = irq_sense_select;
         irq_sense_pkg::OFF_PRIO_A: rd_word[15:0] = prio_a & irq_sense_pkg::PRIO_WRITE_MASK;
         irq_sense_pkg::OFF_PRIO_B: rd_word[15:0] = prio_b & irq_sense_pkg::PRIO_WRITE_MASK;
         irq_sense_pkg::OFF_FLAGS:  rd_word[7:0]  = irq_request_flags;
         irq_sense_pkg::OFF_MASK:   rd_word[7:0]  = irq_mask;
         default:                   rd_hit        = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         axi_arready_out <= 1'b0;
         axi_rvalid_out  <= 1'b0;
         axi_rdata_out   <= '0;
         axi_rresp_out   <= irq_sense_pkg::RESP_OKAY;
      end else begin
         if (ar_take) begin
            axi_arready_out <= 1'b0;
            axi_rvalid_out  <= 1'b1;
            axi_rdata_out   <= rd_word;
            axi_rresp_out   <= rd_hit ? irq_sense_pkg::RESP_OKAY : irq_sense_pkg::RESP_SLVERR;
         end else if (axi_rvalid_out && axi_rready_in) begin
            axi_rvalid_out <= 1'b0;
         end else if (!axi_rvalid_out) begin
            axi_arready_out <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);

   AST_PRIO_LEVELS: assert property (
      cpu_req_out.levels[2:0] == $past(prio_a[14:12]) || !$past(rst_n_in))
      else $error("Pin 0 level does not follow its field.");
   AST_RSVD_READ_ZERO: assert property (
      (ar_take && axi_araddr_in == irq_sense_pkg::OFF_PRIO_A)
      |=> (axi_rdata_out & ~{16'h0000, irq_sense_pkg::PRIO_WRITE_MASK}) == 32'h00000000)
      else $error("Reserved priority bit read as one.");
   AST_PRIO_RESET: assert property (
      $rose(rst_n_in) |-> (prio_a == 16'h7777 && prio_b == 16'h7777))
      else $error("Priority fields not all ones after reset.");
   AST_ENABLE_WRITE: assert property (
      (do_write && aw_addr == irq_sense_pkg::OFF_ENABLE && w_strb[0])
      |=> irq_enable == $past(w_data[7:0]))
      else $error("Enable register missed a write.");
   AST_GATE_ENABLE: assert property (
      $past(rst_n_in) |-> (cpu_req_out.pending & ~$past(irq_enable)) == 8'h00)
      else $error("Disabled request reached the CPU.");
   AST_ENABLE_RESET: assert property (
      $rose(rst_n_in) |-> irq_enable == 8'h00 && cpu_req_out.pending == 8'h00)
      else $error("Enable not clear after reset.");
   AST_SENSE_PIN7: assert property (
      (do_write && aw_addr == irq_sense_pkg::OFF_SENSE && w_strb[1])
      |=> irq_sense_select[15:14] == $past(w_data[15:14]))
      else $error("Pin 7 selector not in bits 15 and 14.");
   AST_SENSE_RESET: assert property (
      $rose(rst_n_in) |-> irq_sense_select == 16'h0000)
      else $error("Selectors not zero after reset.");
   AST_FLAG_SET: assert property (
      (pin_event != 8'h00) |=> (irq_request_flags & $past(pin_event)) == $past(pin_event))
      else $error("Event did not set its flag.");
   AST_FLAG_STICKY: assert property (
      (flag_clear == 8'h00)
      |=> (irq_request_flags & $past(irq_request_flags)) == $past(irq_request_flags))
      else $error("Request flag dropped without a clear.");
   AST_RSVD_HELD: assert property (
      (prio_a & ~irq_sense_pkg::PRIO_WRITE_MASK) == 16'h0000
      && (prio_b & ~irq_sense_pkg::PRIO_WRITE_MASK) == 16'h0000)
      else $error("Reserved priority bit held a one.");
   AST_PENDING_FOLLOW: assert property (
      $past(rst_n_in)
      |-> cpu_req_out.pending == ($past(irq_request_flags) & $past(irq_enable)))
      else $error("Pending requests do not follow flags and enables.");
   AST_IRQ_FOLLOW: assert property (
      $past(rst_n_in) |-> irq_out
         == |($past(irq_request_flags) & $past(irq_enable) & $past(irq_mask)))
      else $error("Interrupt output does not follow the unmasked flags.");

endmodule : irq_sense_enable_priority

//--- verif/ext_pin_model.sv
// Partner model: the external sources that drive the eight request pins.
// Assumes the bench gives the wanted level of each pin; pins idle high.
`timescale 1ns/100ps
module ext_pin_model (
   input  wire logic       sys_clk_in,
   input  wire logic [7:0] level_in,
   output logic      [7:0] pin_n_out
);
   initial pin_n_out = 8'hFF;
   // Each pin follows the bench's wanted level one clock later; a low request is not held.
   always @(posedge sys_clk_in) begin
      pin_n_out <= level_in;
   end
endmodule : ext_pin_model

//--- verif/irq_sense_enable_priority_tb.sv
// Self-checking bench of the external request block.
// Assumes the design's AXI4-Lite map and the partner model ext_pin_model.
`timescale 1ns/100ps
module irq_sense_enable_priority_tb;
   logic                      clk;
   logic                      rst_n;
   logic                      awvalid, wvalid, arvalid, awready, wready, arready;
   logic                      bvalid, rvalid, irq;
   logic [1:0]                bresp, rresp;
   logic [7:0]                awaddr, araddr, lvl, pins;
   logic [31:0]               wdata, rdata;
   irq_sense_pkg::cpu_req_type req;
   logic [33:0]               exp_q[$];
   int                        num_errors = 0;
   int                        n_checks = 0;

   ext_pin_model pins_model (.sys_clk_in(clk), .level_in(lvl), .pin_n_out(pins));
   irq_sense_enable_priority DUT (
      .sys_clk_in(clk), .rst_n_in(rst_n), .ext_request_pin_n_in(pins),
      .axi_awvalid_in(awvalid), .axi_awaddr_in(awaddr), .axi_awprot_in(3'h0),
      .axi_awready_out(awready), .axi_wvalid_in(wvalid), .axi_wdata_in(wdata),
      .axi_wstrb_in(4'hF), .axi_wready_out(wready), .axi_bvalid_out(bvalid),
      .axi_bresp_out(bresp), .axi_bready_in(1'b1), .axi_arvalid_in(arvalid),
      .axi_araddr_in(araddr), .axi_arprot_in(3'h0), .axi_arready_out(arready),
      .axi_rvalid_out(rvalid), .axi_rdata_out(rdata), .axi_rresp_out(rresp),
      .axi_rready_in(1'b1), .cpu_req_out(req), .irq_out(irq));

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic close_out();
      $display("Checks %0d, errors %0d.", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out

   task automatic hang();
      num_errors++;
      close_out();
   endtask : hang

   task automatic check(input logic [33:0] seen, input logic [33:0] want);
      n_checks++;
      if (seen !== want) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
      int   i;
      logic ab, wb, got;
      ab = 1'b1;
      wb = 1'b1;
      got = 1'b0;
      exp_q.push_back({r, 32'h0});
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (i = 0; i < 50 && (ab || wb); i++) begin
         @(posedge clk);
         if (ab && awready) begin
            awvalid <= 1'b0;
            ab = 1'b0;
         end
         if (wb && wready) begin
            wvalid <= 1'b0;
            wb = 1'b0;
         end
      end
      for (i = 0; i < 50 && !got; i++) begin
         @(posedge clk);
         got = bvalid;
      end
      if (!got) hang();
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
      int   i;
      logic got;
      got = 1'b0;
      exp_q.push_back({r, d});
      araddr <= a;
      arvalid <= 1'b1;
      for (i = 0; i < 50 && !got; i++) begin
         @(posedge clk);
         got = arready;
      end
      arvalid <= 1'b0;
      got = 1'b0;
      for (i = 0; i < 50 && !got; i++) begin
         @(posedge clk);
         got = rvalid;
      end
      if (!got) hang();
   endtask : rd

   // ---------------------------------------------------------------
   // Clock, monitor and watchdog
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk) begin
      if (rvalid === 1'b1) check({rresp, rdata}, exp_q.pop_front());
      if (bvalid === 1'b1) check({bresp, 32'h0}, exp_q.pop_front());
   end

   initial begin
      repeat (20000) @(posedge clk);
      hang();
   end

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      int          m, n;
      logic [31:0] pr;
      rst_n = 1'b0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      arvalid = 1'b0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      lvl = 8'hFF;
      void'($urandom(59021));
      pr = $urandom;
      cyc(3);
      rst_n <= 1'b1;
      cyc(1);
      rd(irq_sense_pkg::OFF_ENABLE, 32'h0);
      rd(irq_sense_pkg::OFF_SENSE, 32'h0);
      rd(irq_sense_pkg::OFF_PRIO_B, 32'h7777);
      wr(irq_sense_pkg::OFF_PRIO_A, pr);
      rd(irq_sense_pkg::OFF_PRIO_A, pr & 32'h7777);
      check(34'(req.levels), {10'h000, 12'hFFF, pr[2:0], pr[6:4], pr[10:8], pr[14:12]});
      rd(8'h20, 32'h0, irq_sense_pkg::RESP_SLVERR);
      for (m = 0; m < 4; m++) begin
         n = 2 * m + 1;
         wr(irq_sense_pkg::OFF_SENSE, 32'(m) << (2 * n));
         wr(irq_sense_pkg::OFF_FLAGS, 32'hFF);
         lvl[n] <= 1'b0;
         cyc(10);
         rd(irq_sense_pkg::OFF_FLAGS, 32'(m != 2) << n);
         wr(irq_sense_pkg::OFF_FLAGS, 32'hFF);
         lvl[n] <= 1'b1;
         cyc(10);
         rd(irq_sense_pkg::OFF_FLAGS, 32'(m != 1) << n);
      end
      wr(irq_sense_pkg::OFF_ENABLE, 32'h80);
      wr(irq_sense_pkg::OFF_MASK, 32'h80);
      cyc(2);
      check(34'(req.pending), 34'h80);
      check(34'(irq), 34'h1);
      wr(irq_sense_pkg::OFF_MASK, 32'h0);
      cyc(2);
      check(34'(irq), 34'h0);
      wr(irq_sense_pkg::OFF_ENABLE, 32'h7F);
      cyc(2);
      check(34'(req.pending), 34'h0);
      wr(8'h20, 32'hFF, irq_sense_pkg::RESP_SLVERR);
      rd(irq_sense_pkg::OFF_ENABLE, 32'h7F);
      cyc(2);
      rst_n <= 1'b0;
      cyc(3);
      rst_n <= 1'b1;
      cyc(1);
      rd(irq_sense_pkg::OFF_PRIO_A, 32'h7777);
      rd(irq_sense_pkg::OFF_ENABLE, 32'h0);
      check(34'(irq), 34'h0);
      cyc(2);
      close_out();
   end
endmodule : irq_sense_enable_priority_tb
